// file: logic/mem_order_pkg.sv
package mem_order_pkg;
    // block and word geometry, sequence width
    localparam int BLOCK_OFS_W = 6;
    localparam int QUAD_OFS_W = 3;
    localparam int SEQ_W = 8;
    // store-wait table geometry and clearing intervals in cycles
    localparam int SWT_ENTRIES = 1024;
    localparam int SWT_IDX_W = 10;
    localparam int CLR_SHORT_CYC = 16384;
    localparam int CLR_LONG_CYC = 65536;
    localparam int CLR_CNT_W = 17;
    // reset values
    localparam logic SWT_RESET = 1'h0;
    localparam logic [16:0] CLR_CNT_RESET = 17'h00000;

    typedef enum logic [2:0] {
        MISS_LOAD, MISS_STORE, MISS_COND_STORE, MISS_WRITE_HINT, MISS_EVICT_HINT, MISS_IFETCH
    } miss_kind_t;

    typedef enum logic {TRAP_LOAD_LOAD, TRAP_STORE_LOAD} trap_kind_t;

    // a follows b in program order (wrapping sequence numbers)
    function automatic logic is_newer(input logic [SEQ_W-1:0] a, input logic [SEQ_W-1:0] b);
        logic [SEQ_W-1:0] d;
        d = a - b;
        return !d[SEQ_W-1] && (d != '0);
    endfunction
endpackage

// file: logic/swt_if.sv
`timescale 1ns/10ps
// carries store-wait table set, lookup and interval select
interface swt_if;
    logic set_valid;
    logic [mem_order_pkg::SWT_IDX_W-1:0] set_idx;
    logic [mem_order_pkg::SWT_IDX_W-1:0] rd_idx;
    logic rd_bit;
    logic long_sel;
    modport ctrl (output set_valid, output set_idx, output rd_idx, output long_sel, input rd_bit);
    modport table_side (input set_valid, input set_idx, input rd_idx, input long_sel,
                        output rd_bit);
endinterface

// file: logic/store_wait_table.sv
`timescale 1ns/10ps
module store_wait_table #(
    parameter int CLR_SHORT = mem_order_pkg::CLR_SHORT_CYC,
    parameter int CLR_LONG = mem_order_pkg::CLR_LONG_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // table access
    swt_if.table_side swt
);
    localparam int W = mem_order_pkg::CLR_CNT_W;
    logic [mem_order_pkg::SWT_ENTRIES-1:0] bits_ff;
    logic [W-1:0] clr_cnt_ff;
    wire [W-1:0] clr_limit = swt.long_sel ? W'(CLR_LONG - 1) : W'(CLR_SHORT - 1);
    wire clear_now = (clr_cnt_ff >= clr_limit); // see [RL13]
    wire [W-1:0] nxt_clr_cnt = clear_now ? '0 : clr_cnt_ff + 1'b1;

    // one bit per fetch index, read beside each fetched instruction
    assign swt.rd_bit = bits_ff[swt.rd_idx]; // see [RL10]

    // interval counter
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            clr_cnt_ff <= mem_order_pkg::CLR_CNT_RESET; // see [RL15]
        end else begin
            clr_cnt_ff <= nxt_clr_cnt;
        end
    end

    // per-entry bit: a set in the clearing cycle survives
    for (genvar g = 0; g < mem_order_pkg::SWT_ENTRIES; g++) begin : g_bit
        wire set_here = swt.set_valid && (swt.set_idx == mem_order_pkg::SWT_IDX_W'(g));
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                bits_ff[g] <= mem_order_pkg::SWT_RESET; // see [RL15]
            end else if (set_here) begin
                bits_ff[g] <= 1'b1; // see [RL11]
            end else if (clear_now) begin
                bits_ff[g] <= 1'b0; // see [RL13]
            end
        end
    end

    // checks
    a_clear_all_bits: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see [RL13]
        clear_now && !swt.set_valid |=> bits_ff == '0) else $error("table not cleared");
    a_set_entry_bit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see [RL11]
        swt.set_valid |=> bits_ff[$past(swt.set_idx)]) else $error("store-wait bit not set");
    a_short_interval: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // see [RL13]
        !swt.long_sel && clr_cnt_ff == W'(CLR_SHORT - 1) |-> clear_now)
        else $error("short interval missed");
    c_long_clear: cover property (@(posedge i_core_clk) disable iff (i_sys_rst)
        swt.long_sel && clear_now);
endmodule

// file: logic/mem_order_replay_traps.sv
`timescale 1ns/10ps
// Notes on behaviour
// [RL1] miss requests are whole aligned 64-byte blocks
// [RL2] merge only same-type misses, load joins store
// [RL3] store never merges into pending load entry
// [RL4] same-address memory loads stay in order
// [RL5] memory store order; same-address mixed pairs ordered
// [RL6] I/O loads always ordered; mixed same-address ordered
// [RL7] trap aborts target and newer, refetch target
// [RL8] issuing load traps newer overlapping queued load
// [RL9] issuing store traps newer overlapping queued load
// [RL10] 1024-entry one-bit table read per fetch
// [RL11] store-load trap sets bit at refetch
// [RL12] hold waiting load behind older unissued store
// [RL13] clear table every 16384 or 65536 cycles
// [RL14] newer means later in program order
// [RL15] reset zeroes interval counter and table
module mem_order_replay_traps #(
    parameter int PA_W = 44,
    parameter int LQ_DEPTH = 8,
    parameter int MISS_DEPTH = 8,
    parameter int CLR_SHORT = mem_order_pkg::CLR_SHORT_CYC,
    parameter int CLR_LONG = mem_order_pkg::CLR_LONG_CYC
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // load issue
    input wire logic i_ld_valid,
    input wire logic [mem_order_pkg::SEQ_W-1:0] i_ld_seq,
    input wire logic [PA_W-1:0] i_ld_addr,
    input wire logic [7:0] i_ld_mask,
    input wire logic i_ld_io,
    input wire logic [mem_order_pkg::SWT_IDX_W-1:0] i_ld_pc,
    // store issue
    input wire logic i_st_valid,
    input wire logic [mem_order_pkg::SEQ_W-1:0] i_st_seq,
    input wire logic [PA_W-1:0] i_st_addr,
    input wire logic [7:0] i_st_mask,
    // retirement
    input wire logic i_retire_valid,
    input wire logic [mem_order_pkg::SEQ_W-1:0] i_retire_seq,
    // miss requests and fills
    input wire logic i_miss_valid,
    input wire mem_order_pkg::miss_kind_t i_miss_kind,
    input wire logic [PA_W-1:0] i_miss_addr,
    input wire logic i_fill_valid,
    input wire logic [$clog2(MISS_DEPTH)-1:0] i_fill_idx,
    // fetch and issue-queue side, clear interval select
    input wire logic [mem_order_pkg::SWT_IDX_W-1:0] i_fetch_pc,
    input wire logic i_cand_valid,
    input wire logic [mem_order_pkg::SEQ_W-1:0] i_cand_seq,
    input wire logic i_cand_store_wait,
    input wire logic i_old_st_valid,
    input wire logic [mem_order_pkg::SEQ_W-1:0] i_old_st_seq,
    input wire logic i_long_clear_interval_select,
    // trap outputs and load queue full
    output logic o_trap_valid,
    output mem_order_pkg::trap_kind_t o_trap_kind,
    output logic [mem_order_pkg::SEQ_W-1:0] o_trap_seq,
    output logic o_lq_full,
    // miss outputs
    output logic o_miss_merge,
    output logic o_miss_alloc,
    output logic o_miss_refused,
    output logic [$clog2(MISS_DEPTH)-1:0] o_miss_idx,
    output logic [PA_W-1:0] o_miss_req_addr,
    // fetch and issue outputs
    output logic o_fetch_store_wait,
    output logic o_load_hold
);
    localparam int LQ_IW = $clog2(LQ_DEPTH);
    localparam int MF_IW = $clog2(MISS_DEPTH);
    localparam int QO = mem_order_pkg::QUAD_OFS_W;
    localparam int BO = mem_order_pkg::BLOCK_OFS_W;
    localparam int SW = mem_order_pkg::SEQ_W;

    swt_if swt ();

    // load queue storage
    logic [LQ_DEPTH-1:0] lq_vld_ff;
    logic [SW-1:0] lq_seq_ff [LQ_DEPTH];
    logic [PA_W-1:QO] lq_quad_ff [LQ_DEPTH];
    logic [7:0] lq_mask_ff [LQ_DEPTH];
    logic [LQ_DEPTH-1:0] lq_io_ff;
    logic [mem_order_pkg::SWT_IDX_W-1:0] lq_pc_ff [LQ_DEPTH];
    // miss file storage
    logic [MISS_DEPTH-1:0] mf_vld_ff;
    logic [PA_W-1:BO] mf_blk_ff [MISS_DEPTH];
    mem_order_pkg::miss_kind_t mf_kind_ff [MISS_DEPTH];
    // trap register and refetch index
    logic [mem_order_pkg::SWT_IDX_W-1:0] trap_pc_ff;

    // per-entry order checks against the issuing load and store
    logic [LQ_DEPTH-1:0] ld_hit, st_hit, lq_free, lq_stale;
    for (genvar g = 0; g < LQ_DEPTH; g++) begin : g_cmp
        wire ld_same = (lq_quad_ff[g] == i_ld_addr[PA_W-1:QO]) && |(lq_mask_ff[g] & i_ld_mask);
        wire st_same = (lq_quad_ff[g] == i_st_addr[PA_W-1:QO]) && |(lq_mask_ff[g] & i_st_mask);
        assign ld_hit[g] = i_ld_valid && lq_vld_ff[g] // see [RL8]
            && mem_order_pkg::is_newer(lq_seq_ff[g], i_ld_seq) // see [RL14]
            && (ld_same || (i_ld_io && lq_io_ff[g])); // see [RL4] see [RL6]
        assign st_hit[g] = i_st_valid && lq_vld_ff[g] && st_same // see [RL9] see [RL5]
            && mem_order_pkg::is_newer(lq_seq_ff[g], i_st_seq);
        assign lq_free[g] = !lq_vld_ff[g];
    end

    // pick the oldest trapped load as the restart point
    logic trap_now;
    mem_order_pkg::trap_kind_t tgt_kind;
    logic [SW-1:0] tgt_seq;
    logic [mem_order_pkg::SWT_IDX_W-1:0] tgt_pc;
    logic [LQ_IW-1:0] free_idx;
    always_comb begin
        trap_now = 1'b0;
        tgt_kind = mem_order_pkg::TRAP_LOAD_LOAD;
        tgt_seq = '0;
        tgt_pc = '0;
        free_idx = '0;
        for (int i = LQ_DEPTH - 1; i >= 0; i--) begin
            if (lq_free[i]) begin
                free_idx = LQ_IW'(i);
            end
            if ((ld_hit[i] || st_hit[i]) &&
                (!trap_now || mem_order_pkg::is_newer(tgt_seq, lq_seq_ff[i]))) begin
                trap_now = 1'b1;
                tgt_seq = lq_seq_ff[i];
                tgt_pc = lq_pc_ff[i];
                tgt_kind = st_hit[i] ? mem_order_pkg::TRAP_STORE_LOAD
                                     : mem_order_pkg::TRAP_LOAD_LOAD;
            end
        end
    end

    // the issuing load is dropped if it is itself aborted
    wire ld_killed = (trap_now && !mem_order_pkg::is_newer(tgt_seq, i_ld_seq))
        || (o_trap_valid && !mem_order_pkg::is_newer(o_trap_seq, i_ld_seq));
    wire ld_keep = i_ld_valid && !o_lq_full && !ld_killed;
    wire nxt_lq_full = &(lq_vld_ff | (LQ_DEPTH'(ld_keep) << free_idx));

    // load queue entries: allocate, retire, flush on trap
    for (genvar g = 0; g < LQ_DEPTH; g++) begin : g_lq
        wire kill = trap_now && !mem_order_pkg::is_newer(tgt_seq, lq_seq_ff[g]); // see [RL7]
        wire retire = i_retire_valid && !mem_order_pkg::is_newer(lq_seq_ff[g], i_retire_seq);
        wire alloc = ld_keep && (free_idx == LQ_IW'(g));
        assign lq_stale[g] = lq_vld_ff[g] && !mem_order_pkg::is_newer(o_trap_seq, lq_seq_ff[g]);
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                lq_vld_ff[g] <= 1'b0;
            end else if (alloc) begin
                lq_vld_ff[g] <= 1'b1;
            end else if (kill || retire) begin
                lq_vld_ff[g] <= 1'b0;
            end
        end
        always_ff @(posedge i_core_clk) begin
            if (alloc) begin
                lq_seq_ff[g] <= i_ld_seq;
                lq_quad_ff[g] <= i_ld_addr[PA_W-1:QO];
                lq_mask_ff[g] <= i_ld_mask;
                lq_io_ff[g] <= i_ld_io;
                lq_pc_ff[g] <= i_ld_pc;
            end
        end
    end

    // trap outputs; a store-load trap marks the table during refetch
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_trap_valid <= 1'b0;
            o_trap_kind <= mem_order_pkg::TRAP_LOAD_LOAD;
            o_trap_seq <= '0;
            trap_pc_ff <= '0;
            o_lq_full <= 1'b0;
        end else begin
            o_trap_valid <= trap_now; // see [RL7]
            o_trap_kind <= tgt_kind;
            o_trap_seq <= tgt_seq;
            trap_pc_ff <= tgt_pc;
            o_lq_full <= nxt_lq_full;
        end
    end
    assign swt.set_valid = o_trap_valid
        && (o_trap_kind == mem_order_pkg::TRAP_STORE_LOAD); // see [RL11]
    assign swt.set_idx = trap_pc_ff;
    assign swt.rd_idx = i_fetch_pc;
    assign swt.long_sel = i_long_clear_interval_select; // see [RL13]

    store_wait_table #(.CLR_SHORT(CLR_SHORT), .CLR_LONG(CLR_LONG)) u_swt (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .swt(swt.table_side)
    );

    // miss file merge decode: like types, or a load onto a store
    logic [MISS_DEPTH-1:0] mf_hit, mf_free;
    for (genvar g = 0; g < MISS_DEPTH; g++) begin : g_mf
        wire same_blk = mf_vld_ff[g] && (mf_blk_ff[g] == i_miss_addr[PA_W-1:BO]); // see [RL1]
        wire kind_ok = (mf_kind_ff[g] == i_miss_kind) // see [RL2]
            || (mf_kind_ff[g] == mem_order_pkg::MISS_STORE
                && i_miss_kind == mem_order_pkg::MISS_LOAD); // see [RL3]
        assign mf_hit[g] = i_miss_valid && same_blk && kind_ok;
        assign mf_free[g] = !mf_vld_ff[g];
    end
    logic [MF_IW-1:0] hit_idx, mf_free_idx;
    always_comb begin
        hit_idx = '0;
        mf_free_idx = '0;
        for (int i = MISS_DEPTH - 1; i >= 0; i--) begin
            if (mf_hit[i]) begin
                hit_idx = MF_IW'(i);
            end
            if (mf_free[i]) begin
                mf_free_idx = MF_IW'(i);
            end
        end
    end
    wire merge_now = |mf_hit;
    wire alloc_now = i_miss_valid && !merge_now && |mf_free;

    // miss file entries
    for (genvar g = 0; g < MISS_DEPTH; g++) begin : g_mfe
        wire take = alloc_now && (mf_free_idx == MF_IW'(g));
        always_ff @(posedge i_core_clk) begin
            if (i_sys_rst) begin
                mf_vld_ff[g] <= 1'b0;
                mf_kind_ff[g] <= mem_order_pkg::MISS_LOAD;
                mf_blk_ff[g] <= '0;
            end else if (take) begin
                mf_vld_ff[g] <= 1'b1;
                mf_kind_ff[g] <= i_miss_kind;
                mf_blk_ff[g] <= i_miss_addr[PA_W-1:BO];
            end else if (i_fill_valid && i_fill_idx == MF_IW'(g)) begin
                mf_vld_ff[g] <= 1'b0;
            end
        end
    end

    // miss answers; a new block request is always block aligned
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_miss_merge <= 1'b0;
            o_miss_alloc <= 1'b0;
            o_miss_refused <= 1'b0;
            o_miss_idx <= '0;
            o_miss_req_addr <= '0;
        end else begin
            o_miss_merge <= merge_now;
            o_miss_alloc <= alloc_now;
            o_miss_refused <= i_miss_valid && !merge_now && !alloc_now;
            o_miss_idx <= merge_now ? hit_idx : mf_free_idx;
            o_miss_req_addr <= {i_miss_addr[PA_W-1:BO], BO'(0)}; // see [RL1]
        end
    end

    // fetch bit and issue hold
    wire nxt_load_hold = i_cand_valid && i_cand_store_wait && i_old_st_valid
        && mem_order_pkg::is_newer(i_cand_seq, i_old_st_seq); // see [RL12]
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_fetch_store_wait <= 1'b0;
            o_load_hold <= 1'b0;
        end else begin
            o_fetch_store_wait <= swt.rd_bit; // see [RL10]
            o_load_hold <= nxt_load_hold;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    a_trap_on_hit: assert property (|(ld_hit | st_hit) |=> o_trap_valid) // see [RL8]
        else $error("missed order trap");
    a_ll_trap_kind: assert property ((ld_hit != '0) && (st_hit == '0) |=> // see [RL8]
        o_trap_kind == mem_order_pkg::TRAP_LOAD_LOAD
        && mem_order_pkg::is_newer(o_trap_seq, $past(i_ld_seq))) else $error("bad load trap");
    a_sl_trap_kind: assert property ((st_hit != '0) && (ld_hit == '0) |=> // see [RL9]
        o_trap_kind == mem_order_pkg::TRAP_STORE_LOAD
        && mem_order_pkg::is_newer(o_trap_seq, $past(i_st_seq))) else $error("bad store trap");
    a_no_false_trap: assert property (!(|(ld_hit | st_hit)) |=> !o_trap_valid) // see [RL14]
        else $error("spurious trap");
    a_flush_newer: assert property (o_trap_valid |-> lq_stale == '0) // see [RL7]
        else $error("newer load survived trap");
    a_merge_kind: assert property (o_miss_merge |-> // see [RL3]
        mf_kind_ff[o_miss_idx] == $past(i_miss_kind)
        || (mf_kind_ff[o_miss_idx] == mem_order_pkg::MISS_STORE
            && $past(i_miss_kind) == mem_order_pkg::MISS_LOAD)) else $error("bad merge type");
    a_block_aligned: assert property (o_miss_alloc |-> o_miss_req_addr[BO-1:0] == '0 // see [RL1]
        && o_miss_req_addr[PA_W-1:BO] == $past(i_miss_addr[PA_W-1:BO]))
        else $error("request not block aligned");
    a_hold_release: assert property (!i_old_st_valid |=> !o_load_hold) // see [RL12]
        else $error("hold not released");
    c_ll_trap: cover property (o_trap_valid && o_trap_kind == mem_order_pkg::TRAP_LOAD_LOAD);
    c_sl_trap: cover property (swt.set_valid ##1 o_fetch_store_wait);
    c_load_on_store: cover property (o_miss_merge
        && mf_kind_ff[o_miss_idx] == mem_order_pkg::MISS_STORE);
endmodule

// file: dv/issue_queue_model.sv
`timescale 1ns/10ps
// issue queue model: one load candidate waiting behind one unissued store
module issue_queue_model (
    // clock
    input wire logic i_core_clk,
    // bench commands
    input wire logic i_start,
    input wire logic i_wait,
    input wire logic i_older,
    input wire logic [7:0] i_stall,
    // design side
    input wire logic i_load_hold,
    output logic o_cand_valid,
    output logic [7:0] o_cand_seq,
    output logic o_cand_store_wait,
    output logic o_old_st_valid,
    output logic [7:0] o_old_st_seq,
    // issue report
    output logic o_issued,
    output logic [7:0] o_issue_cyc
);
    logic [7:0] cyc_ff;
    // nothing is presented before the first command
    initial begin
        o_cand_valid = 1'b0;
        o_cand_seq = 8'h00;
        o_cand_store_wait = 1'b0;
        o_old_st_valid = 1'b0;
        o_old_st_seq = 8'h00;
        o_issued = 1'b0;
        o_issue_cyc = 8'h00;
        cyc_ff = 8'h00;
    end
    // present, issue the store after the stall, issue the load once hold is seen low
    always @(posedge i_core_clk) begin
        o_issued <= 1'b0;
        if (i_start) begin
            o_cand_valid <= 1'b1;
            o_cand_seq <= 8'h60;
            o_cand_store_wait <= i_wait;
            o_old_st_valid <= 1'b1;
            o_old_st_seq <= i_older ? 8'h5c : 8'h64;
            cyc_ff <= 8'h00;
        end else if (o_cand_valid) begin
            cyc_ff <= cyc_ff + 8'h01;
            if (cyc_ff + 8'h01 == i_stall) begin
                o_old_st_valid <= 1'b0; // last older store issues
                o_old_st_seq <= ~o_old_st_seq;
            end
            // hold is registered, so the first cycle's value is not trusted
            if (cyc_ff != 8'h00 && !i_load_hold) begin
                o_cand_valid <= 1'b0;
                o_cand_seq <= ~o_cand_seq;
                o_issued <= 1'b1;
                o_issue_cyc <= cyc_ff + 8'h01;
            end
        end
    end
endmodule

// file: dv/tb_mem_order_replay_traps.sv
`timescale 1ns/10ps
module tb_mem_order_replay_traps;
    localparam int PA_W = 44;
    localparam int CS = 16;
    localparam int CL = 64;
    localparam logic [PA_W-1:0] A = 44'h12340;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_ld_valid = 1'b0, i_ld_io = 1'b0, i_st_valid = 1'b0, i_retire_valid = 1'b0;
    logic i_miss_valid = 1'b0, i_fill_valid = 1'b0, i_long_clear_interval_select = 1'b0;
    logic [7:0] i_ld_seq = 8'h00, i_ld_mask = 8'h00, i_st_seq = 8'h00, i_st_mask = 8'h00;
    logic [7:0] i_retire_seq = 8'h00;
    logic [PA_W-1:0] i_ld_addr = '0, i_st_addr = '0, i_miss_addr = '0;
    logic [9:0] i_ld_pc = 10'h155, i_fetch_pc = 10'h155;
    mem_order_pkg::miss_kind_t i_miss_kind = mem_order_pkg::MISS_LOAD;
    logic [2:0] i_fill_idx = 3'h0;
    logic q_start = 1'b0, q_wait = 1'b0, q_older = 1'b0, q_issued;
    logic [7:0] q_stall = 8'h01, q_issue_cyc, i_cand_seq, i_old_st_seq, o_trap_seq;
    logic i_cand_valid, i_cand_store_wait, i_old_st_valid, o_trap_valid, o_lq_full;
    logic o_miss_merge, o_miss_alloc, o_miss_refused, o_fetch_store_wait, o_load_hold;
    mem_order_pkg::trap_kind_t o_trap_kind;
    logic [2:0] o_miss_idx;
    logic [PA_W-1:0] o_miss_req_addr;
    int num_errors = 0, checks_done = 0, seed = 48, cyc = 0;
    logic [31:0] r;
    logic mv [8] = '{default: 1'b0};
    mem_order_pkg::miss_kind_t mk [8];
    logic [PA_W-7:0] mb [8];

    mem_order_replay_traps #(.CLR_SHORT(CS), .CLR_LONG(CL)) mem_order_replay_traps_inst (
        .i_core_clk, .i_sys_rst, .i_ld_valid, .i_ld_seq, .i_ld_addr, .i_ld_mask, .i_ld_io,
        .i_ld_pc, .i_st_valid, .i_st_seq, .i_st_addr, .i_st_mask, .i_retire_valid,
        .i_retire_seq, .i_miss_valid, .i_miss_kind, .i_miss_addr, .i_fill_valid, .i_fill_idx,
        .i_fetch_pc, .i_cand_valid, .i_cand_seq, .i_cand_store_wait, .i_old_st_valid,
        .i_old_st_seq, .i_long_clear_interval_select, .o_trap_valid, .o_trap_kind,
        .o_trap_seq, .o_lq_full, .o_miss_merge, .o_miss_alloc, .o_miss_refused, .o_miss_idx,
        .o_miss_req_addr, .o_fetch_store_wait, .o_load_hold
    );
    issue_queue_model issue_queue_model_inst (
        .i_core_clk, .i_start(q_start), .i_wait(q_wait), .i_older(q_older), .i_stall(q_stall),
        .i_load_hold(o_load_hold), .o_cand_valid(i_cand_valid), .o_cand_seq(i_cand_seq),
        .o_cand_store_wait(i_cand_store_wait), .o_old_st_valid(i_old_st_valid),
        .o_old_st_seq(i_old_st_seq), .o_issued(q_issued), .o_issue_cyc(q_issue_cyc)
    );

    // clock and free-running cycle count
    always #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) cyc <= cyc + 1;

    // comparisons, report and closing
    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk_val(input logic [PA_W-1:0] g, input logic [PA_W-1:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: value %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        $display("Error at %0t: wait ran out", $time);
        stop_test();
    endtask

    // one load or store issue, then the trap answer in the following cycle
    task automatic mem_op(input logic st, input logic [7:0] seq, input logic [PA_W-1:0] a,
                          input logic [7:0] m, input logic io, input logic et,
                          input logic [7:0] es);
        @(posedge i_core_clk);
        i_ld_valid <= !st;
        i_st_valid <= st;
        i_ld_seq <= seq;
        i_st_seq <= seq;
        i_ld_addr <= a;
        i_st_addr <= a;
        i_ld_mask <= m;
        i_st_mask <= m;
        i_ld_io <= io;
        @(posedge i_core_clk);
        i_ld_valid <= 1'b0;
        i_st_valid <= 1'b0;
        #1;
        chk_bit(o_trap_valid, et);
        if (et) begin
            chk_bit(o_trap_kind, st);
            chk_val(PA_W'(o_trap_seq), PA_W'(es));
        end
    endtask
    task automatic retire(input logic [7:0] s);
        @(posedge i_core_clk);
        i_retire_valid <= 1'b1;
        i_retire_seq <= s;
        @(posedge i_core_clk);
        i_retire_valid <= 1'b0;
    endtask
    task automatic fill(input logic [2:0] x);
        @(posedge i_core_clk);
        i_fill_valid <= 1'b1;
        i_fill_idx <= x;
        @(posedge i_core_clk);
        i_fill_valid <= 1'b0;
        mv[x] = 1'b0;
    endtask

    // miss request checked against a bench copy of the miss entries
    task automatic miss(input mem_order_pkg::miss_kind_t k, input logic [PA_W-1:0] a);
        logic [7:0] hit;
        int fr;
        hit = 8'h00;
        fr = -1;
        for (int i = 0; i < 8; i++) begin
            hit[i] = mv[i] && mb[i] == a[PA_W-1:6] && (mk[i] == k ||
                     (k == mem_order_pkg::MISS_LOAD && mk[i] == mem_order_pkg::MISS_STORE));
            if (!mv[i]) fr = i;
        end
        @(posedge i_core_clk);
        i_miss_valid <= 1'b1;
        i_miss_kind <= k;
        i_miss_addr <= a;
        @(posedge i_core_clk);
        i_miss_valid <= 1'b0;
        #1;
        chk_bit(o_miss_merge, hit != 8'h00);
        chk_bit(o_miss_refused, hit == 8'h00 && fr < 0);
        if (hit != 8'h00) chk_bit(hit[o_miss_idx], 1'b1);
        if (hit == 8'h00 && fr >= 0) begin
            chk_bit(mv[o_miss_idx], 1'b0);
            chk_val(o_miss_req_addr, {a[PA_W-1:6], 6'h00});
            mv[o_miss_idx] = 1'b1;
            mk[o_miss_idx] = k;
            mb[o_miss_idx] = a[PA_W-1:6];
        end
    endtask

    // two successive table clears must lie exactly one interval apart
    task automatic clear_gap(input logic lng, input int lim);
        int t [2];
        int n;
        @(posedge i_core_clk);
        i_long_clear_interval_select <= lng;
        for (int k = 0; k < 2; k++) begin
            mem_op(1'b0, 8'h50, A, 8'hff, 1'b0, 1'b0, 8'h00);
            mem_op(1'b1, 8'h4f, A, 8'hff, 1'b0, 1'b1, 8'h50);
            repeat (2) @(posedge i_core_clk);
            #1;
            chk_bit(o_fetch_store_wait, 1'b1);
            n = 0;
            while (o_fetch_store_wait === 1'b1 && n < lim + 8) begin
                @(posedge i_core_clk);
                #1;
                n++;
            end
            if (n >= lim + 8) hang();
            t[k] = cyc;
        end
        chk_val(PA_W'(t[1] - t[0]), PA_W'(lim));
    endtask

    // held load must issue two cycles after the last older store
    task automatic hold_case(input logic w, input logic old, input logic [7:0] stall);
        int n;
        @(posedge i_core_clk);
        q_start <= 1'b1;
        q_wait <= w;
        q_older <= old;
        q_stall <= stall;
        @(posedge i_core_clk);
        q_start <= 1'b0;
        n = 0;
        while (q_issued !== 1'b1 && n < 20) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (n >= 20) hang();
        chk_val(PA_W'(q_issue_cyc), (w && old) ? PA_W'(stall) + 44'h2 : 44'h2);
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk_bit(o_trap_valid | o_load_hold | o_fetch_store_wait | o_miss_alloc, 1'b0);
        mem_op(1'b0, 8'h08, A, 8'h0f, 1'b0, 1'b0, 8'h00);
        mem_op(1'b0, 8'h0a, A, 8'hf0, 1'b0, 1'b0, 8'h00);
        mem_op(1'b0, 8'h06, A, 8'h0f, 1'b0, 1'b1, 8'h08);
        mem_op(1'b1, 8'h07, A, 8'hf0, 1'b0, 1'b0, 8'h00);
        retire(8'h10);
        mem_op(1'b0, 8'h25, A, 8'h01, 1'b1, 1'b0, 8'h00);
        mem_op(1'b0, 8'h23, A + 44'h100, 8'h01, 1'b1, 1'b1, 8'h25);
        mem_op(1'b0, 8'h28, A + 44'h200, 8'hff, 1'b0, 1'b0, 8'h00);
        mem_op(1'b0, 8'h27, A + 44'h208, 8'hff, 1'b0, 1'b0, 8'h00);
        mem_op(1'b1, 8'h26, A + 44'h240, 8'hff, 1'b0, 1'b0, 8'h00);
        mem_op(1'b1, 8'h29, A + 44'h200, 8'hff, 1'b0, 1'b0, 8'h00);
        mem_op(1'b0, 8'h36, A, 8'h0f, 1'b0, 1'b0, 8'h00);
        mem_op(1'b0, 8'h34, A, 8'hf0, 1'b0, 1'b0, 8'h00);
        mem_op(1'b1, 8'h31, A, 8'hff, 1'b0, 1'b1, 8'h34);
        repeat (2) @(posedge i_core_clk);
        #1;
        chk_bit(o_fetch_store_wait, 1'b1);
        retire(8'h40);
        clear_gap(1'b0, CS);
        clear_gap(1'b1, CL);
        // a second reset wipes a freshly set table bit
        mem_op(1'b0, 8'h50, A, 8'hff, 1'b0, 1'b0, 8'h00);
        mem_op(1'b1, 8'h4f, A, 8'hff, 1'b0, 1'b1, 8'h50);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        #1;
        chk_bit(o_fetch_store_wait, 1'b0);
        hold_case(1'b1, 1'b1, 8'h01);
        hold_case(1'b1, 1'b0, 8'h03);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            hold_case(r[0], r[1], 8'h01 + {5'h00, r[4:2]});
        end
        miss(mem_order_pkg::MISS_STORE, 44'h1010);
        miss(mem_order_pkg::MISS_LOAD, 44'h1038);
        miss(mem_order_pkg::MISS_LOAD, 44'h1040);
        miss(mem_order_pkg::MISS_STORE, 44'h1048);
        for (int k = 0; k < 6; k++) begin
            miss(mem_order_pkg::miss_kind_t'(k), 44'h1100 + PA_W'(k * 64));
            miss(mem_order_pkg::miss_kind_t'(k), 44'h1130 + PA_W'(k * 64));
        end
        for (int i = 0; i < 8; i++) begin
            if (mv[i]) fill(3'(i));
        end
        for (int i = 0; i < 150; i++) begin
            r = $random(seed);
            miss(mem_order_pkg::miss_kind_t'(r[14:12] % 6), 44'h4000 + PA_W'(r[7:0]));
            if ((r[20] || o_miss_refused) && mv[r[18:16]]) fill(r[18:16]);
        end
        stop_test();
    end
endmodule
